//--- bit_test_skip_defines.vh
// Constants for the bit test and skip execution block.
// Contract
// - Opcode 1011 skips next when bit clear.
// - Opcode 1010 skips next when bit set.
// - Skip flushes prefetched word, runs NOP.
// - One word; 1, 2 or 3 cycles.
// - Access flag 0 selects access bank.
// - Access flag 1 uses bank select register.
// - Extended set, a=0, f<=95 uses indexed offset.
`ifndef BIT_TEST_SKIP_DEFINES_VH
`define BIT_TEST_SKIP_DEFINES_VH
`define OPC_SKIP_IF_CLEAR 4'hB
`define OPC_SKIP_IF_SET 4'hA
`define OPC_MSB 15
`define OPC_LSB 12
`define BIT_MSB 11
`define BIT_LSB 9
`define ACCESS_BIT 8
`define FILE_MSB 7
`define FILE_LSB 0
`define INDEXED_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_BANK 4'hF
`endif

//--- skip_word_table.v
// Table that marks which opcodes are the first word of a two-word instruction.
`timescale 1ns/1ps
module skip_word_table #(
	parameter DEPTH = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Lookup
	input wire [3:0] addr_i,
	input wire [DEPTH-1:0] table_i,
	output reg two_word_o
);
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			two_word_o <= 1'b0;
		end else begin
			two_word_o <= table_i[addr_i];
		end
	end
endmodule // skip_word_table

//--- bit_test_skip_execution.v
// Decode and execution of the two bit test and skip instructions.
`timescale 1ns/1ps
`include "bit_test_skip_defines.vh"
module bit_test_skip_execution #(
	parameter [15:0] TWO_WORD_OPCODES = 16'h2000
) (
	// Clock and reset
	input wire SYS_CLK_I,
	input wire SYS_RST_I,
	// Instruction stream
	input wire INSTR_VALID_I,
	input wire [15:0] INSTR_I,
	input wire [15:0] NEXT_INSTR_I,
	// Operand context
	input wire EXTENDED_SET_I,
	input wire [3:0] BANK_SELECT_REGISTER_I,
	input wire [7:0] FSR2_BASE_I,
	// Tested register data
	input wire [7:0] FILE_DATA_I,
	// Operand address
	output reg [11:0] FILE_ADDR_O,
	output reg INDEXED_O,
	// Execution result
	output reg IS_TEST_O,
	output reg SKIP_O,
	output reg FLUSH_O,
	output reg [1:0] CYCLES_O
);
	// ****************************************
	// Decode
	// ****************************************
	localparam ST_IDLE = 3'b001;
	localparam ST_NOP1 = 3'b010;
	localparam ST_NOP2 = 3'b100;

	wire [3:0] opc = INSTR_I[`OPC_MSB:`OPC_LSB];
	wire [2:0] bit_sel = INSTR_I[`BIT_MSB:`BIT_LSB];
	wire acc = INSTR_I[`ACCESS_BIT];
	wire [7:0] faddr = INSTR_I[`FILE_MSB:`FILE_LSB];
	wire is_clr = (opc == `OPC_SKIP_IF_CLEAR);
	wire is_set = (opc == `OPC_SKIP_IF_SET);
	wire tbit = FILE_DATA_I[bit_sel];
	wire take = INSTR_VALID_I & ((is_clr & ~tbit) | (is_set & tbit));
	wire two_word;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [11:0] addr_d;
	reg idx_d;

	// The lookup is registered, so the next word is judged one cycle later.
	skip_word_table #(
		.DEPTH(16)
	) u_table (
		.clk_i(SYS_CLK_I),
		.rst_i(SYS_RST_I),
		.addr_i(NEXT_INSTR_I[15:12]),
		.table_i(TWO_WORD_OPCODES),
		.two_word_o(two_word)
	);

	// ****************************************
	// Address resolution
	// ****************************************
	always @* begin
		idx_d = 1'b0;
		if (acc) begin
			addr_d = {BANK_SELECT_REGISTER_I, faddr};
		end else if (EXTENDED_SET_I && faddr <= `INDEXED_LIMIT) begin
			idx_d = 1'b1;
			addr_d = {4'h0, FSR2_BASE_I + faddr};
		end else if (faddr < `ACCESS_SPLIT) begin
			addr_d = {4'h0, faddr};
		end else begin
			addr_d = {`ACCESS_HIGH_BANK, faddr};
		end
	end

	// ****************************************
	// Skip sequencing
	// ****************************************
	always @* begin
		case (state_q)
			ST_IDLE: begin
				state_d = (take && (is_clr || is_set)) ? ST_NOP1 : ST_IDLE;
			end
			ST_NOP1: begin
				state_d = two_word ? ST_NOP2 : ST_IDLE;
			end
			ST_NOP2: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Only address, flush, flags and cycle count leave here; no status or file write exists.
	always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state_q <= ST_IDLE;
			FILE_ADDR_O <= 12'h000;
			INDEXED_O <= 1'b0;
			IS_TEST_O <= 1'b0;
			SKIP_O <= 1'b0;
			FLUSH_O <= 1'b0;
			CYCLES_O <= 2'h0;
		end else begin
			state_q <= state_d;
			FILE_ADDR_O <= addr_d;
			INDEXED_O <= idx_d & INSTR_VALID_I & (is_clr | is_set);
			IS_TEST_O <= (state_q == ST_IDLE) & INSTR_VALID_I & (is_clr | is_set);
			SKIP_O <= (state_q == ST_IDLE) & take;
			FLUSH_O <= (state_q == ST_IDLE) ? take : (state_q == ST_NOP1) & two_word;
			if (state_q == ST_IDLE && INSTR_VALID_I && (is_clr || is_set)) begin
				CYCLES_O <= take ? 2'h2 : 2'h1;
			end else if (state_q == ST_NOP1 && two_word) begin
				CYCLES_O <= 2'h3;
			end
		end
	end
endmodule // bit_test_skip_execution

//--- bit_test_skip_execution_chk.sv
// Checker for the bit test and skip block.
`timescale 1ns/1ps
module bit_test_skip_execution_chk #(parameter [15:0] TWO_WORD_OPCODES = 16'h2000) (
	input wire SYS_CLK_I, SYS_RST_I, INSTR_VALID_I, EXTENDED_SET_I,
	input wire INDEXED_O, IS_TEST_O, SKIP_O, FLUSH_O,
	input wire [15:0] INSTR_I, NEXT_INSTR_I,
	input wire [7:0] FILE_DATA_I,
	input wire [3:0] BANK_SELECT_REGISTER_I,
	input wire [11:0] FILE_ADDR_O,
	input wire [1:0] CYCLES_O);
	wire [7:0] f = INSTR_I[7:0];
	wire tk = INSTR_VALID_I && !FLUSH_O && INSTR_I[15:13] == 3'h5;
	wire sk = tk && FILE_DATA_I[INSTR_I[11:9]] != INSTR_I[12];
	wire ac = tk && !INSTR_I[8] && !(EXTENDED_SET_I && f <= 8'h5F);
	wire [11:0] aa = {f < 8'h60 ? 4'h0 : 4'hF, f};
	wire [11:0] ba = {BANK_SELECT_REGISTER_I, f};
	wire tw = TWO_WORD_OPCODES[NEXT_INSTR_I[15:12]];
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	property p_tk; tk |=> IS_TEST_O; endproperty
	a_tk: assert property (p_tk) else $error("tk");
	property p_sk; sk |=> SKIP_O && FLUSH_O && CYCLES_O == 2'h2; endproperty
	a_sk: assert property (p_sk) else $error("sk");
	property p_ns; tk && !sk |=> !SKIP_O && !FLUSH_O && CYCLES_O == 2'h1; endproperty
	a_ns: assert property (p_ns) else $error("ns");
	property p_tw; SKIP_O && $past(tw) |=> FLUSH_O && CYCLES_O == 2'h3; endproperty
	a_tw: assert property (p_tw) else $error("tw");
	property p_ac; ac |=> FILE_ADDR_O == $past(aa) && !INDEXED_O; endproperty
	a_ac: assert property (p_ac) else $error("ac");
	property p_bs; tk && INSTR_I[8] |=> FILE_ADDR_O == $past(ba) && !INDEXED_O; endproperty
	a_bs: assert property (p_bs) else $error("bs");
	property p_ix; tk && !INSTR_I[8] && !ac |=> INDEXED_O; endproperty
	a_ix: assert property (p_ix) else $error("ix");
	property p_fl; FLUSH_O |-> SKIP_O || $past(SKIP_O); endproperty
	a_fl: assert property (p_fl) else $error("fl");
endmodule // bit_test_skip_execution_chk
bind bit_test_skip_execution bit_test_skip_execution_chk #(.TWO_WORD_OPCODES(TWO_WORD_OPCODES)) chk_u (.*);

//--- bit_test_skip_execution_tb_top.sv
// Random bench for the bit test and skip block.
`timescale 1ns/1ps
module bit_test_skip_execution_tb_top;
	reg SYS_CLK_I = 0, SYS_RST_I = 1, INSTR_VALID_I = 0, EXTENDED_SET_I = 0;
	reg [15:0] INSTR_I = 0, NEXT_INSTR_I = 0;
	reg [7:0] FSR2_BASE_I = 0, FILE_DATA_I = 0;
	reg [3:0] BANK_SELECT_REGISTER_I = 0;
	wire [11:0] FILE_ADDR_O;
	wire INDEXED_O, IS_TEST_O, SKIP_O, FLUSH_O;
	wire [1:0] CYCLES_O;
	reg [1:0] e;
	integer bad_count = 0, num_checks = 0, i;
	always #4 SYS_CLK_I = ~SYS_CLK_I;
	bit_test_skip_execution #(.TWO_WORD_OPCODES(16'h0004)) dut_u (.*);
	function [11:0] ea(input [15:0] w, input [3:0] b, input x, input [7:0] base);
		ea = w[8] ? {b, w[7:0]} : (x && w[7:0] <= 8'h5F) ? {4'h0, base + w[7:0]} :
			{(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
	endfunction
	task ck(input [63:0] n, input [11:0] x, input [11:0] y);
		num_checks = num_checks + 1;
		if (x !== y) begin
			bad_count = bad_count + 1;
			$display("ERROR %0s expected %0d seen %0d", n, x, y);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#9000;
		bad_count = bad_count + 1;
		results;
	end
	initial begin
		i = $urandom(74);
		repeat (12) @(negedge SYS_CLK_I);
		SYS_RST_I = 0;
		for (i = 0; i < 200; i = i + 1) begin
			@(negedge SYS_CLK_I);
			{INSTR_I, NEXT_INSTR_I, FILE_DATA_I, BANK_SELECT_REGISTER_I, EXTENDED_SET_I, FSR2_BASE_I} = {$urandom, $urandom};
			INSTR_I[15:13] = 3'h5;
			INSTR_VALID_I = 1;
			if (i < 8) FILE_DATA_I = {8{i[0]}};
			if (i[1]) NEXT_INSTR_I[15:12] = 4'h2;
			e = FILE_DATA_I[INSTR_I[11:9]] == INSTR_I[12] ? 2'h1 : NEXT_INSTR_I[15:12] == 4'h2 ? 2'h3 : 2'h2;
			@(negedge SYS_CLK_I);
			INSTR_VALID_I = 0;
			ck("SKIP_O", e > 2'h1, SKIP_O);
			ck("FLUSH_O", e > 2'h1, FLUSH_O);
			ck("IS_TEST", 12'h001, IS_TEST_O);
			ck("ADDR", ea(INSTR_I, BANK_SELECT_REGISTER_I, EXTENDED_SET_I, FSR2_BASE_I), FILE_ADDR_O);
			repeat (2) @(negedge SYS_CLK_I);
			ck("CYCLES_O", e, CYCLES_O);
		end
		results;
	end
endmodule // bit_test_skip_execution_tb_top
